// *** hw/vsc_pkg.sv ***
package vsc_pkg;

  // Word and code widths
  localparam int unsigned VSC_WORD_W = 8;
  localparam int unsigned VSC_CODE_W = 9;

  // Bit counter: one code per nine bit periods, no gaps
  localparam int unsigned VSC_CNT_W   = 4;
  localparam logic [3:0]  VSC_CNT_RST = 4'h0;
  localparam logic [3:0]  VSC_CNT_ONE = 4'h1;
  localparam logic [3:0]  VSC_BIT_LAST = 4'h8;

  // Input words that own two complementary codes
  localparam logic [7:0] VSC_DUAL_LO  = 8'h00;
  localparam logic [7:0] VSC_DUAL_HI  = 8'hFF;
  localparam logic [7:0] VSC_DUAL_A_LO = 8'h38;
  localparam logic [7:0] VSC_DUAL_A_HI = 8'h44;
  localparam logic [7:0] VSC_DUAL_B_LO = 8'h62;
  localparam logic [7:0] VSC_DUAL_B_HI = 8'h6F;
  localparam logic [7:0] VSC_DUAL_C_LO = 8'h92;
  localparam logic [7:0] VSC_DUAL_C_HI = 8'h9F;

  // Reset values
  localparam logic [8:0] VSC_CODE_RST = 9'h000;
  localparam logic [7:0] VSC_WORD_RST = 8'h00;

endpackage

// *** hw/vsc_shift9.sv ***
`timescale 1ns/10ps
// Nine-bit shift register, loads in parallel or shifts toward bit zero
module vsc_shift9 (
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic                                load,
  input  wire logic [vsc_pkg::VSC_CODE_W-1:0]      load_val,
  input  wire logic                                shift_in,
  output logic      [vsc_pkg::VSC_CODE_W-1:0]      value_q
);
  import vsc_pkg::*;

  logic [VSC_CODE_W-1:0] value_d;

  // Load wins, otherwise shift right with new bit entering at the top
  always_comb begin
    if (load) begin
      value_d = load_val;
    end else begin
      value_d = {shift_in, value_q[VSC_CODE_W-1:1]};
    end
  end

  // Register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      value_q <= VSC_CODE_RST;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

// *** hw/vsc_codec.sv ***
`timescale 1ns/10ps
module vsc_codec (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire logic [vsc_pkg::VSC_WORD_W-1:0]    tx_word,
  output logic                                   tx_take,
  output logic                                   tx_serial,
  input  wire logic                              rx_serial,
  input  wire logic                              rx_frame,
  output logic      [vsc_pkg::VSC_WORD_W-1:0]    rx_word,
  output logic                                   rx_valid,
  output logic                                   rx_code_err
);
  import vsc_pkg::*;

  // Primary code column, indexed by the input word
  localparam logic [8:0] CODE_TAB [256] = '{
    9'h0FE, 9'h027, 9'h1D8, 9'h033, 9'h1CC, 9'h037, 9'h1CB, 9'h039,
    9'h1C6, 9'h03B, 9'h1C4, 9'h03D, 9'h1C2, 9'h14D, 9'h0B4, 9'h14B,
    9'h1A2, 9'h0B6, 9'h149, 9'h0BA, 9'h145, 9'h0CA, 9'h135, 9'h0D2,
    9'h12D, 9'h0D4, 9'h129, 9'h0D6, 9'h125, 9'h0DA, 9'h115, 9'h0EA,
    9'h0B2, 9'h02B, 9'h1D4, 9'h02D, 9'h1D2, 9'h035, 9'h1CA, 9'h04B,
    9'h1B4, 9'h04D, 9'h1B2, 9'h053, 9'h1AC, 9'h057, 9'h1A8, 9'h059,
    9'h1A6, 9'h05B, 9'h05D, 9'h1A4, 9'h065, 9'h19A, 9'h069, 9'h196,
    9'h026, 9'h08C, 9'h02C, 9'h098, 9'h032, 9'h0BE, 9'h034, 9'h0C2,
    9'h046, 9'h0C4, 9'h04C, 9'h0C8, 9'h058, 9'h0B1, 9'h14E, 9'h0B3,
    9'h14C, 9'h0B9, 9'h06B, 9'h194, 9'h06D, 9'h192, 9'h075, 9'h18A,
    9'h08B, 9'h174, 9'h08D, 9'h172, 9'h093, 9'h16C, 9'h097, 9'h168,
    9'h099, 9'h166, 9'h09B, 9'h164, 9'h09D, 9'h162, 9'h0A3, 9'h15C,
    9'h0A7, 9'h158, 9'h025, 9'h0A1, 9'h029, 9'h091, 9'h045, 9'h089,
    9'h049, 9'h085, 9'h051, 9'h08A, 9'h0A4, 9'h054, 9'h0A2, 9'h052,
    9'h056, 9'h1A9, 9'h05A, 9'h1A5, 9'h06A, 9'h195, 9'h096, 9'h169,
    9'h0A9, 9'h156, 9'h0AB, 9'h154, 9'h0A5, 9'h15A, 9'h0AD, 9'h152,
    9'h155, 9'h0AA, 9'h055, 9'h1AA, 9'h0D5, 9'h12A, 9'h095, 9'h16A,
    9'h0B5, 9'h14A, 9'h09A, 9'h165, 9'h0A6, 9'h159, 9'h0AC, 9'h153,
    9'h0AE, 9'h151, 9'h02A, 9'h092, 9'h04A, 9'h094, 9'h0A8, 9'h0B7,
    9'h0F5, 9'h0BB, 9'h0ED, 9'h0BD, 9'h0EB, 9'h0D7, 9'h0DD, 9'h0DB,
    9'h146, 9'h0C5, 9'h13A, 9'h0C9, 9'h136, 9'h0CB, 9'h134, 9'h0CD,
    9'h132, 9'h0D1, 9'h12E, 9'h0D3, 9'h12C, 9'h0D9, 9'h126, 9'h0E5,
    9'h11A, 9'h0E9, 9'h116, 9'h02E, 9'h1D1, 9'h036, 9'h1C9, 9'h03A,
    9'h1C5, 9'h04E, 9'h1B1, 9'h05C, 9'h1A3, 9'h05E, 9'h1A1, 9'h066,
    9'h199, 9'h06C, 9'h193, 9'h06E, 9'h191, 9'h072, 9'h18D, 9'h074,
    9'h18B, 9'h07A, 9'h189, 9'h08E, 9'h185, 9'h09C, 9'h171, 9'h09E,
    9'h163, 9'h0B8, 9'h161, 9'h0BC, 9'h147, 9'h0C6, 9'h143, 9'h0CC,
    9'h139, 9'h0CE, 9'h133, 9'h0D8, 9'h131, 9'h0DC, 9'h127, 9'h0E2,
    9'h123, 9'h0E4, 9'h11D, 9'h0E6, 9'h11B, 9'h0E8, 9'h119, 9'h0EC,
    9'h117, 9'h0F2, 9'h113, 9'h0F4, 9'h10D, 9'h076, 9'h10B, 9'h0C7,
    9'h13C, 9'h047, 9'h1B8, 9'h067, 9'h19C, 9'h071, 9'h198, 9'h073,
    9'h18E, 9'h079, 9'h18C, 9'h087, 9'h186, 9'h0C3, 9'h178, 9'h062
  };

  // True for words that own a complementary second code
  function automatic logic is_dual(input logic [7:0] w);
    is_dual = (w == VSC_DUAL_LO) || (w == VSC_DUAL_HI) ||
              ((w >= VSC_DUAL_A_LO) && (w <= VSC_DUAL_A_HI)) ||
              ((w >= VSC_DUAL_B_LO) && (w <= VSC_DUAL_B_HI)) ||
              ((w >= VSC_DUAL_C_LO) && (w <= VSC_DUAL_C_HI));
  endfunction

  // Reverse lookup; lowest matching word wins, found flags a legal code
  function automatic logic [8:0] decode(input logic [8:0] c);
    logic       found;
    logic [7:0] word;
    found = 1'b0;
    word  = VSC_WORD_RST;
    for (int i = 0; i < 256; i++) begin
      if (!found && ((CODE_TAB[i] == c) ||
          (is_dual(8'(i)) && (~CODE_TAB[i] == c)))) begin
        found = 1'b1;
        word  = 8'(i);
      end
    end
    decode = {found, word};
  endfunction

  // Transmit state
  logic [VSC_CNT_W-1:0]  tx_cnt_q;
  logic [VSC_CNT_W-1:0]  tx_cnt_d;
  logic                  alt_q;
  logic                  alt_d;
  logic                  take_q;
  logic                  take_d;
  logic                  tx_load;
  logic [VSC_CODE_W-1:0] tx_code;
  logic [VSC_CODE_W-1:0] tx_shift_q;

  // Word pacing, code selection and alternation
  always_comb begin
    tx_load = (tx_cnt_q == VSC_BIT_LAST);
    tx_cnt_d = tx_load ? VSC_CNT_RST : tx_cnt_q + VSC_CNT_ONE;
    take_d = (tx_cnt_d == VSC_BIT_LAST);
    tx_code = CODE_TAB[tx_word];
    alt_d = alt_q;
    if (tx_load && is_dual(tx_word)) begin
      if (alt_q) begin
        tx_code = ~CODE_TAB[tx_word];
      end
      alt_d = ~alt_q;
    end
  end

  // Transmit registers; toggle resets to primary column
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_q <= VSC_CNT_RST;
      alt_q    <= 1'b0;
      take_q   <= 1'b0;
    end else begin
      tx_cnt_q <= tx_cnt_d;
      alt_q    <= alt_d;
      take_q   <= take_d;
    end
  end

  // Serializer: bit zero leaves first, one bit per clock
  vsc_shift9 u_tx_shift (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (tx_load),
    .load_val (tx_code),
    .shift_in (1'b0),
    .value_q  (tx_shift_q)
  );

  assign tx_take   = take_q;
  assign tx_serial = tx_shift_q[0];

  // Receive pin synchronisers
  logic rx_data_m_q;
  logic rx_data_s_q;
  logic rx_frm_m_q;
  logic rx_frm_s_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_data_m_q <= 1'b0;
      rx_data_s_q <= 1'b0;
      rx_frm_m_q  <= 1'b0;
      rx_frm_s_q  <= 1'b0;
    end else begin
      rx_data_m_q <= rx_serial;
      rx_data_s_q <= rx_data_m_q;
      rx_frm_m_q  <= rx_frame;
      rx_frm_s_q  <= rx_frm_m_q;
    end
  end

  // Receive state
  logic [VSC_CNT_W-1:0]  rx_cnt_q;
  logic [VSC_CNT_W-1:0]  rx_cnt_d;
  logic                  rx_aligned_q;
  logic                  rx_aligned_d;
  logic                  rx_done_q;
  logic                  rx_done_d;
  logic [VSC_CODE_W-1:0] rx_shift_q;
  logic [8:0]            rx_dec;
  logic [VSC_WORD_W-1:0] rx_word_q;
  logic [VSC_WORD_W-1:0] rx_word_d;
  logic                  rx_valid_q;
  logic                  rx_err_q;
  logic                  rx_err_d;

  // Deserializer: earliest bit ends up at bit zero after nine shifts
  vsc_shift9 u_rx_shift (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (1'b0),
    .load_val (VSC_CODE_RST),
    .shift_in (rx_data_s_q),
    .value_q  (rx_shift_q)
  );

  // Word alignment from frame marker, then decode of a full code
  always_comb begin
    rx_aligned_d = rx_aligned_q | rx_frm_s_q;
    if (rx_frm_s_q) begin
      rx_cnt_d = VSC_CNT_ONE;
    end else if (rx_cnt_q == VSC_BIT_LAST) begin
      rx_cnt_d = VSC_CNT_RST;
    end else begin
      rx_cnt_d = rx_cnt_q + VSC_CNT_ONE;
    end
    rx_done_d = rx_aligned_q && !rx_frm_s_q && (rx_cnt_q == VSC_BIT_LAST);
    rx_dec    = decode(rx_shift_q);
    rx_word_d = rx_word_q;
    rx_err_d  = rx_err_q;
    if (rx_done_q) begin
      rx_word_d = rx_dec[7:0];
      rx_err_d  = ~rx_dec[8];
    end
  end

  // Receive registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_cnt_q     <= VSC_CNT_RST;
      rx_aligned_q <= 1'b0;
      rx_done_q    <= 1'b0;
      rx_word_q    <= VSC_WORD_RST;
      rx_valid_q   <= 1'b0;
      rx_err_q     <= 1'b0;
    end else begin
      rx_cnt_q     <= rx_cnt_d;
      rx_aligned_q <= rx_aligned_d;
      rx_done_q    <= rx_done_d;
      rx_word_q    <= rx_word_d;
      rx_valid_q   <= rx_done_q;
      rx_err_q     <= rx_err_d;
    end
  end

  assign rx_word     = rx_word_q;
  assign rx_valid    = rx_valid_q;
  assign rx_code_err = rx_err_q;

endmodule

// *** testbench/vsc_codec_assertions.sv ***
`timescale 1ns/10ps
// Port-level checks of the codec
module vsc_codec_chk (
  input wire logic                           sys_clk,
  input wire logic                           rst,
  input wire logic [vsc_pkg::VSC_WORD_W-1:0] tx_word,
  input wire logic                           tx_take,
  input wire logic                           tx_serial,
  input wire logic                           rx_serial,
  input wire logic                           rx_frame,
  input wire logic [vsc_pkg::VSC_WORD_W-1:0] rx_word,
  input wire logic                           rx_valid,
  input wire logic                           rx_code_err
);
  import vsc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Word slots every nine bits, no gaps
  take_period_a: assert property (tx_take |=> !tx_take [*8] ##1 tx_take)
    else $error("tx_take spacing wrong");
  rx_spacing_a: assert property (rx_valid |=> !rx_valid [*8])
    else $error("rx_valid too close");
  rx_hold_a: assert property (!rx_valid |-> $stable(rx_word))
    else $error("rx_word moved without rx_valid");
  err_word_a: assert property (rx_code_err |-> rx_word == 8'h00)
    else $error("bad code left nonzero word");
  rx_latency_a: assert property (rx_frame |-> ##12 rx_valid)
    else $error("decoded word late or missing");
  // Single code 155 sent bit zero first, one is high
  code_single_a: assert property (tx_take && tx_word == 8'h80 |=> tx_serial ##1 !tx_serial
    ##1 tx_serial ##1 !tx_serial ##1 tx_serial ##1 !tx_serial ##1 tx_serial ##1 !tx_serial
    ##1 tx_serial) else $error("word 80 not sent as 155");
  code_ten_a: assert property (tx_take && tx_word == 8'h10 |=> !tx_serial ##1 tx_serial
    ##1 !tx_serial [*3] ##1 tx_serial ##1 !tx_serial ##1 tx_serial [*2])
    else $error("word 10 not sent as 1A2");
  dual_alt_a: assert property (tx_take && tx_word == 8'h00 ##9 tx_take && tx_word == 8'h00
    |=> tx_serial != $past(tx_serial, 9)) else $error("dual code did not alternate");
endmodule

bind vsc_codec vsc_codec_chk u_chk (.sys_clk(sys_clk), .rst(rst), .tx_word(tx_word),
  .tx_take(tx_take), .tx_serial(tx_serial), .rx_serial(rx_serial), .rx_frame(rx_frame),
  .rx_word(rx_word), .rx_valid(rx_valid), .rx_code_err(rx_code_err));

// *** testbench/vsc_far_end.sv ***
`timescale 1ns/10ps
// Remote receiver: rebuilds codes, loops the line back with a word marker
module vsc_far_end (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       tx_serial,
  input  wire logic       tx_take,
  input  wire logic       line_flip,
  output logic      [8:0] code_q,
  output logic            code_valid_q,
  output logic            rx_serial,
  output logic            rx_frame_q
);
  logic [8:0] sr_q;
  logic       seen_q;

  // Loopback with fault injection: a high flip inverts the bit on the line
  assign rx_serial = tx_serial ^ line_flip;
  // First bit in lands at bit zero; nine bits per slot, gapless
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sr_q         <= 9'h000;
      code_q       <= 9'h000;
      code_valid_q <= 1'b0;
      seen_q       <= 1'b0;
      rx_frame_q   <= 1'b0;
    end else begin
      sr_q         <= {tx_serial, sr_q[8:1]};
      code_valid_q <= tx_take & seen_q;
      rx_frame_q   <= tx_take; // Bit zero follows the take edge
      if (tx_take) begin
        code_q <= {tx_serial, sr_q[8:1]};
        seen_q <= 1'b1;
      end
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import vsc_pkg::*;
  logic       sys_clk, rst, rx_serial, rx_frame, code_valid, tx_take, tx_serial;
  logic       rx_valid, rx_code_err, alt_m, line_flip;
  logic [7:0] tx_word, rx_word, w, cw, ew;
  logic [8:0] code, prim [256];
  logic       pv [256];
  logic [8:0] txq [$];
  logic [8:0] rxq [$];
  int         err_count, check_count, n;
  logic [31:0] x;

  vsc_codec dut (.sys_clk(sys_clk), .rst(rst), .tx_word(tx_word), .tx_take(tx_take),
    .tx_serial(tx_serial), .rx_serial(rx_serial), .rx_frame(rx_frame), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_code_err(rx_code_err));
  vsc_far_end far (.sys_clk(sys_clk), .rst(rst), .tx_serial(tx_serial), .tx_take(tx_take),
    .line_flip(line_flip), .code_q(code), .code_valid_q(code_valid), .rx_serial(rx_serial),
    .rx_frame_q(rx_frame));

  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic dual(logic [7:0] v);
    return v == VSC_DUAL_LO || v == VSC_DUAL_HI || (v >= VSC_DUAL_A_LO && v <= VSC_DUAL_A_HI)
      || (v >= VSC_DUAL_B_LO && v <= VSC_DUAL_B_HI) || (v >= VSC_DUAL_C_LO && v <= VSC_DUAL_C_HI);
  endfunction
  task automatic check(string name, logic [8:0] seen, logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Codes seen at the far end and words decoded back
  always @(posedge sys_clk) begin
    #1;
    if (code_valid && txq.size() > 0) begin
      cw = txq[0][7:0];
      if (pv[cw]) check("tx_code", code, txq[0][8] ? ~prim[cw] : prim[cw]);
      else prim[cw] = txq[0][8] ? ~code : code;
      pv[cw] = 1'b1;
      void'(txq.pop_front());
    end
    if (rx_valid && rxq.size() > 0) begin
      check("rx_word", {1'b0, rx_word}, {1'b0, rxq[0][7:0]});
      check("rx_code_err", {8'h00, rx_code_err}, {8'h00, rxq[0][8]});
      void'(rxq.pop_front());
    end
  end

  initial begin
    rst = 1'b1;
    tx_word = 8'h00;
    line_flip = 1'b0;
    alt_m = 1'b0;
    x = 32'haa1b;
    for (int i = 0; i < 256; i++) pv[i] = 1'b0;
    prim[8'h00] = 9'h0FE; prim[8'h80] = 9'h155; prim[8'hFF] = 9'h062;
    prim[8'h10] = 9'h1A2; prim[8'h3B] = 9'h098;
    pv[8'h00] = 1; pv[8'h80] = 1; pv[8'hFF] = 1; pv[8'h10] = 1; pv[8'h3B] = 1;
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 90; i++) begin
      n = 0;
      while (tx_take !== 1'b1) begin
        @(posedge sys_clk);
        #1 n++;
        if (n > 20) begin
          err_count++;
          end_sim();
        end
      end
      x = xs(x);
      case (i)
        0, 1, 8, 11, 13: w = 8'h00;
        2, 9, 10: w = 8'h80;
        3, 12: w = 8'h10;
        4, 5: w = 8'h3B;
        6, 7: w = 8'hFF;
        default: w = (i % 3 == 0) ? (x[7:0] & 8'h47) : x[7:0];
      endcase
      tx_word = w;
      txq.push_back({dual(w) & alt_m, w});
      // Complement 1CB of word 3E is also the code of 06, which decodes first
      ew = (w == 8'h3E && alt_m) ? 8'h06 : w;
      rxq.push_back((i == 13) ? {1'b1, 8'h00} : {1'b0, ew});
      if (dual(w)) alt_m = ~alt_m;
      @(posedge sys_clk);
      // Word 13 has its first bit inverted on the line: no legal code then
      #1 line_flip = (i == 13);
      @(posedge sys_clk);
      #1 line_flip = 1'b0;
    end
    repeat (40) @(posedge sys_clk);
    end_sim();
  end
endmodule
